//--- include/arvs_defs.vh
// Constants for the task-file read, verify, recalibrate, sense and seek block.
// Assumes a 32-bit Avalon-MM slave on a 25 MHz clock.
`ifndef ARVS_DEFS_VH
`define ARVS_DEFS_VH
// ==========================================================
// Register word offsets
`define ARVS_OFF_CMD      4'h0
`define ARVS_OFF_SECCNT   4'h1
`define ARVS_OFF_SECNUM   4'h2
`define ARVS_OFF_CYLLO    4'h3
`define ARVS_OFF_CYLHI    4'h4
`define ARVS_OFF_DRVHD    4'h5
`define ARVS_OFF_STATUS   4'h6
`define ARVS_OFF_ERROR    4'h7
`define ARVS_OFF_DATA     4'h8
`define ARVS_OFF_IRQSTAT  4'h9
`define ARVS_OFF_IRQEN    4'ha
`define ARVS_OFF_IRQCLR   4'hb
`define ARVS_OFF_MAXLBA   4'hc
`define ARVS_OFF_MEDIA    4'hd
// ==========================================================
// Opcodes
`define ARVS_OP_READ0     8'h20
`define ARVS_OP_READ1     8'h21
`define ARVS_OP_VER0      8'h40
`define ARVS_OP_VER1      8'h41
`define ARVS_OP_SENSE     8'h03
`define ARVS_NIB_RECAL    4'h1
`define ARVS_NIB_SEEK     4'h7
// ==========================================================
// Status bits
`define ARVS_ST_BSY       7
`define ARVS_ST_RDY       6
`define ARVS_ST_DRQ       3
`define ARVS_ST_ERR       0
// Error register bits
`define ARVS_ER_ABRT      8'h04
`define ARVS_ER_IDNF      8'h10
`define ARVS_ER_UNC       8'h40
// Interrupt event bits
`define ARVS_EV_SECTOR    0
`define ARVS_EV_DONE      1
`define ARVS_EV_ERROR     2
// ==========================================================
// Extended error codes
`define ARVS_XE_NONE      8'h00
`define ARVS_XE_SELFOK    8'h01
`define ARVS_XE_MISC      8'h09
`define ARVS_XE_BADADDR   8'h21
`define ARVS_XE_OVERFLOW  8'h2f
`define ARVS_XE_VOLT      8'h35
`define ARVS_XE_UNCORR    8'h11
`define ARVS_XE_CORR      8'h18
`define ARVS_XE_DIAG      8'h05
`define ARVS_XE_IDNF      8'h10
`define ARVS_XE_SPARE     8'h3a
`define ARVS_XE_ABORT     8'h1f
`define ARVS_XE_FORMAT    8'h38
`define ARVS_XE_WRFAIL    8'h03
// ==========================================================
// Sizes and timing
`define ARVS_WORDS        8'hff
`define ARVS_MAXLBA_RST   28'h0ffffff
`define ARVS_LOAD_NS      800
`define ARVS_CLK_NS       40
`define ARVS_LOAD_CYC     ((`ARVS_LOAD_NS + `ARVS_CLK_NS - 1) / `ARVS_CLK_NS)
`endif

//--- rtl/arvs_core.v
// Task-file command executor for read, verify, recalibrate, sense, seek.
// Assumes an Avalon-MM master on ref_clk; media is modelled by a
// software-set fault register and generated sector data.
`timescale 1ns/1ps
`include "arvs_defs.vh"

// What this block does
// - Opcode 20h or 21h reads 1 to 256 sectors from the count register.
// - A count of zero means 256 sectors.
// - The transfer starts at the address held in the task-file registers.
// - Per sector: busy, load buffer, data request, clear busy, interrupt.
// - Read error stops at failing sector, keeps its address and data.
// - Opcode 40h or 41h verifies like read but never requests data.
// - Verify sets busy, then clears it and interrupts when done.
// - Verify error keeps failing address and count of unverified sectors.
// - Opcodes 1Xh complete at once with no media work.
// - Opcode 03h puts the previous extended error code in error register.
// - Codes 21h bad address, 2Fh overflow, 10h or 14h ID not found.
// - Codes 11h uncorrectable, 18h corrected, 3Ah spares gone, 03h write.
// - Codes 05h, 30-34h, 37h, 3Eh diagnostics; 35h, 36h voltage.
// - Code 1Fh transfer error or abort; 38h, 3Bh, 3Ch, 3Fh format.
// - Opcodes 7Xh range-check the address and flag an error if beyond.
module arvs_core (
  input wire ref_clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire irq
);

  // ==========================================================
  // States
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_LOAD = 5'b00010;
  localparam [4:0] S_XFER = 5'b00100;
  localparam [4:0] S_VER = 5'b01000;
  localparam [4:0] S_DONE = 5'b10000;
  localparam integer LOAD_N = `ARVS_LOAD_CYC;
  localparam [5:0] LOAD_CYC = LOAD_N[5:0];

  reg [4:0] st_q;
  reg [7:0] seccnt_q, secnum_q, cyllo_q, cylhi_q, drvhd_q;
  reg [7:0] status_q, error_q, xerr_q;
  reg [8:0] left_q;
  reg [7:0] widx_q;
  reg [5:0] tmr_q;
  reg verify_q;
  reg [2:0] ists_q, ien_q;
  reg [27:0] maxlba_q;
  reg [27:0] bad_lba_q;
  reg [7:0] bad_code_q;
  wire [15:0] buf_w [0:255];
  reg ack_q;
  reg [31:0] rdata_d;
  reg [2:0] ev_q;

  wire [27:0] lba = {drvhd_q[3:0], cylhi_q, cyllo_q, secnum_q};
  wire [27:0] lba_inc = lba + 28'h0000001;
  wire busy = status_q[`ARVS_ST_BSY];
  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  wire rd = avs_read & ack_q;
  wire wr = avs_write & ack_q;
  // Read data is latched in the wait cycle so it stands at acceptance
  wire rd_cap = avs_read & ~ack_q;
  assign irq = |(ists_q & ien_q);
  wire cmd_wr = wr && avs_address == `ARVS_OFF_CMD && !busy &&
    !status_q[`ARVS_ST_DRQ];
  wire [7:0] op = avs_writedata[7:0];

  // ==========================================================
  // Command decode
  wire op_media = op == `ARVS_OP_READ0 || op == `ARVS_OP_READ1 ||
    op == `ARVS_OP_VER0 || op == `ARVS_OP_VER1;
  wire op_recal = op[7:4] == `ARVS_NIB_RECAL;
  wire op_seek = op[7:4] == `ARVS_NIB_SEEK;
  wire op_sense = op == `ARVS_OP_SENSE;

  // ==========================================================
  // Media checks
  wire data_rd = rd && avs_address == `ARVS_OFF_DATA &&
    status_q[`ARVS_ST_DRQ];
  wire hit_bad = (bad_lba_q == lba) && (bad_code_q != `ARVS_XE_NONE);
  wire out_rng = lba > maxlba_q;
  wire [7:0] fail_code = out_rng ? `ARVS_XE_BADADDR : bad_code_q;
  wire fail = out_rng | hit_bad;
  // Corrected: keep going, but only on the sector that is flagged
  wire corr = fail && (fail_code == `ARVS_XE_CORR);

  // ==========================================================
  // Bus slave and registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (rd_cap)
        avs_readdata <= rdata_d;
    end
  end

  // ==========================================================
  // Read data mux; the word index only moves on acceptance
  always @* begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `ARVS_OFF_SECCNT: rdata_d = {24'h000000, seccnt_q};
      `ARVS_OFF_SECNUM: rdata_d = {24'h000000, secnum_q};
      `ARVS_OFF_CYLLO: rdata_d = {24'h000000, cyllo_q};
      `ARVS_OFF_CYLHI: rdata_d = {24'h000000, cylhi_q};
      `ARVS_OFF_DRVHD: rdata_d = {24'h000000, drvhd_q};
      `ARVS_OFF_STATUS: rdata_d = {24'h000000, status_q};
      `ARVS_OFF_ERROR: rdata_d = {24'h000000, error_q};
      `ARVS_OFF_DATA: begin
        if (status_q[`ARVS_ST_DRQ])
          rdata_d = {16'h0000, buf_w[widx_q]};
      end
      `ARVS_OFF_IRQSTAT: rdata_d = {29'h0000000, ists_q};
      `ARVS_OFF_IRQEN: rdata_d = {29'h0000000, ien_q};
      `ARVS_OFF_MAXLBA: rdata_d = {4'h0, maxlba_q};
      `ARVS_OFF_MEDIA: rdata_d = {bad_code_q, 24'h000000};
      default: rdata_d = 32'h00000000;
    endcase
  end

  // ==========================================================
  // Sector buffer: generated from the LBA, so a flawed sector's data
  // still sits in the buffer after the read stops
  wire buf_load = st_q == S_LOAD && tmr_q == 6'd0 && !verify_q;
  genvar g;
  generate
    for (g = 0; g < 256; g = g + 1) begin : g_word
      localparam integer GI = g;
      localparam [15:0] IDX = GI[15:0];
      reg [15:0] word_q;
      always @(posedge ref_clk) begin
        if (buf_load)
          word_q <= lba[15:0] ^ IDX;
      end
      assign buf_w[g] = word_q;
    end
  endgenerate

  // ==========================================================
  // Command sequencer
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      seccnt_q <= 8'h01;
      secnum_q <= 8'h01;
      cyllo_q <= 8'h00;
      cylhi_q <= 8'h00;
      drvhd_q <= 8'ha0;
      status_q <= 8'h40;
      error_q <= 8'h00;
      xerr_q <= `ARVS_XE_NONE;
      left_q <= 9'h000;
      widx_q <= 8'h00;
      tmr_q <= 6'h00;
      verify_q <= 1'b0;
      ien_q <= 3'h0;
      maxlba_q <= `ARVS_MAXLBA_RST;
      bad_lba_q <= 28'h0000000;
      bad_code_q <= `ARVS_XE_NONE;
      ev_q <= 3'b000;
    end else begin
      // Events are one-cycle pulses, latched by the interrupt status
      ev_q <= 3'b000;
      if (wr && !busy) begin
        case (avs_address)
          `ARVS_OFF_SECCNT: seccnt_q <= avs_writedata[7:0];
          `ARVS_OFF_SECNUM: secnum_q <= avs_writedata[7:0];
          `ARVS_OFF_CYLLO: cyllo_q <= avs_writedata[7:0];
          `ARVS_OFF_CYLHI: cylhi_q <= avs_writedata[7:0];
          `ARVS_OFF_DRVHD: drvhd_q <= avs_writedata[7:0];
          `ARVS_OFF_IRQEN: ien_q <= avs_writedata[2:0];
          `ARVS_OFF_MAXLBA: maxlba_q <= avs_writedata[27:0];
          `ARVS_OFF_MEDIA: begin
            bad_lba_q <= avs_writedata[27:0];
            bad_code_q <= {4'h0, avs_writedata[31:28]} |
              (avs_writedata[31:28] == 4'h0 ? 8'h00 : 8'h10);
          end
          default: ;
        endcase
      end
      case (st_q)
        S_IDLE: begin
          if (cmd_wr) begin
            status_q <= 8'h40;
            error_q <= 8'h00;
            if (op_media) begin
              status_q[`ARVS_ST_BSY] <= 1'b1;
              verify_q <= op[6];
              left_q <= (seccnt_q == 8'h00) ? 9'h100 :
                {1'b0, seccnt_q};
              tmr_q <= LOAD_CYC;
              xerr_q <= `ARVS_XE_NONE;
              st_q <= op[6] ? S_VER : S_LOAD;
            end else if (op_recal) begin
              xerr_q <= `ARVS_XE_NONE;
              ev_q[`ARVS_EV_DONE] <= 1'b1;
            end else if (op_seek) begin
              ev_q[`ARVS_EV_DONE] <= 1'b1;
              if (out_rng) begin
                status_q[`ARVS_ST_ERR] <= 1'b1;
                error_q <= `ARVS_ER_IDNF;
                xerr_q <= `ARVS_XE_BADADDR;
                ev_q[`ARVS_EV_ERROR] <= 1'b1;
              end else begin
                xerr_q <= `ARVS_XE_NONE;
              end
            end else if (op_sense) begin
              error_q <= xerr_q;
              ev_q[`ARVS_EV_DONE] <= 1'b1;
            end else begin
              status_q[`ARVS_ST_ERR] <= 1'b1;
              error_q <= `ARVS_ER_ABRT;
              xerr_q <= `ARVS_XE_ABORT;
              ev_q[`ARVS_EV_ERROR] <= 1'b1;
            end
          end
        end
        S_LOAD, S_VER: begin
          if (tmr_q != 6'd0) begin
            tmr_q <= tmr_q - 6'd1;
          end else if (fail && !corr) begin
            // Stop here; address registers still name this sector
            status_q <= 8'h41;
            error_q <= (fail_code == `ARVS_XE_UNCORR) ? `ARVS_ER_UNC :
              `ARVS_ER_IDNF;
            xerr_q <= fail_code;
            seccnt_q <= left_q[7:0];
            ev_q[`ARVS_EV_ERROR] <= 1'b1;
            // Flawed data stays readable after a read error
            if (!verify_q) begin
              status_q[`ARVS_ST_DRQ] <= 1'b1;
              widx_q <= 8'h00;
              st_q <= S_XFER;
            end else begin
              st_q <= S_IDLE;
            end
          end else begin
            if (corr)
              xerr_q <= `ARVS_XE_CORR;
            if (verify_q) begin
              left_q <= left_q - 9'd1;
              seccnt_q <= left_q[7:0] - 8'd1;
              {drvhd_q[3:0], cylhi_q, cyllo_q, secnum_q} <= lba_inc;
              if (left_q == 9'd1) begin
                status_q[`ARVS_ST_BSY] <= 1'b0;
                ev_q[`ARVS_EV_DONE] <= 1'b1;
                st_q <= S_IDLE;
              end else begin
                tmr_q <= LOAD_CYC;
              end
            end else begin
              status_q[`ARVS_ST_BSY] <= 1'b0;
              status_q[`ARVS_ST_DRQ] <= 1'b1;
              ev_q[`ARVS_EV_SECTOR] <= 1'b1;
              widx_q <= 8'h00;
              st_q <= S_XFER;
            end
          end
        end
        S_XFER: begin
          if (data_rd) begin
            widx_q <= widx_q + 8'd1;
            if (widx_q == `ARVS_WORDS) begin
              status_q[`ARVS_ST_DRQ] <= 1'b0;
              if (status_q[`ARVS_ST_ERR] || left_q == 9'd1) begin
                st_q <= S_IDLE;
              end else begin
                left_q <= left_q - 9'd1;
                seccnt_q <= left_q[7:0] - 8'd1;
                {drvhd_q[3:0], cylhi_q, cyllo_q, secnum_q} <= lba_inc;
                status_q[`ARVS_ST_BSY] <= 1'b1;
                tmr_q <= LOAD_CYC;
                st_q <= S_LOAD;
              end
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Interrupt status: set wins over a clear in the same cycle
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      ists_q <= 3'h0;
    else
      ists_q <= (ists_q & ~((wr && avs_address == `ARVS_OFF_IRQCLR) ?
        avs_writedata[2:0] : 3'h0)) | ev_q;
  end

endmodule

//--- testbench/arvs_monitor.sv
// Checker for the arvs_core bus and interrupt ports.
// Assumes a master that holds each request until accepted.
`timescale 1ns/1ps
module arvs_mon (
  input wire ref_clk,
  input wire rstn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire irq
);
  // ==========================================================
  // Enable shadow, since only the ports are visible here
  reg [2:0] en_q;
  wire wr_acc = avs_write && !avs_waitrequest;
  wire rd_acc = avs_read && !avs_waitrequest;
  always @(posedge ref_clk or negedge rstn)
    if (!rstn) en_q <= 3'h0;
    else if (wr_acc && avs_address == 4'ha) en_q <= avs_writedata[2:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_wait_first: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  a_wait_idle: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest) else $error("idle wait");
  a_irq_enabled: assert property (
    irq |-> (en_q != 3'h0 || $past(en_q) != 3'h0)) else $error("irq masked");
  a_irq_off: assert property (
    wr_acc && avs_address == 4'ha && avs_writedata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("irq stays");
  a_en_readback: assert property (
    rd_acc && avs_address == 4'ha |-> avs_readdata[2:0] == en_q)
    else $error("enable readback");
  a_unmapped_zero: assert property (
    rd_acc && avs_address >= 4'he |-> avs_readdata == 32'h0)
    else $error("unmapped data");
  a_data_hold: assert property (
    !avs_read |=> $stable(avs_readdata)) else $error("readdata moved");
endmodule
bind arvs_core arvs_mon i_mon (.ref_clk, .rstn, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);

//--- testbench/arvs_host.sv
// Host controller model: Avalon-MM master with noted expectations.
// Assumes the caller enters each task just after a rising edge.
`timescale 1ns/1ps
module arvs_host (
  input wire ref_clk,
  output logic [3:0] avs_address = 4'h0,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  // ==========================================================
  // Bus cycles; an edge passes after release so strobes never clash
  typedef struct {logic [31:0] e; logic [31:0] m; string n;} arvs_note_t;
  arvs_note_t notes_q[$];
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m,
      input string n, output logic [31:0] q);
    notes_q.push_back('{e, m, n});
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule

//--- testbench/arvs_core_bench.sv
// Bench for arvs_core: read, verify, seek, recalibrate, sense, abort.
// Assumes arvs_host as bus master and arvs_mon bound to the core.
`timescale 1ns/1ps
module arvs_core_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  wire [3:0] avs_address;
  wire avs_read;
  wire avs_write;
  wire [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire irq;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] q;
  logic [27:0] lba;
  logic [7:0] op [3];
  logic [7:0] ext [3];
  always #20 ref_clk = ~ref_clk;
  arvs_core i_dut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .irq);
  arvs_host i_host (.ref_clk, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  // ==========================================================
  // Helpers
  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic r(input logic [3:0] a, input logic [31:0] e, m,
      input string n);
    i_host.rd(a, e, m, n, q);
  endtask
  task automatic w(input logic [3:0] a, input logic [31:0] d);
    i_host.wr(a, d);
  endtask
  task automatic load(input logic [27:0] a, input logic [7:0] c);
    w(4'h2, {24'h0, a[7:0]});
    w(4'h3, {24'h0, a[15:8]});
    w(4'h4, {24'h0, a[23:16]});
    w(4'h5, {24'h0, 4'he, a[27:24]});
    w(4'h1, {24'h0, c});
  endtask
  // Oldest note is compared when a read is accepted, unless its mask is zero
  always @(posedge ref_clk)
    if (rstn && avs_read && !avs_waitrequest) begin
      if (i_host.notes_q[0].m !== 32'h0)
        chk(i_host.notes_q[0].n, i_host.notes_q[0].e & i_host.notes_q[0].m,
          avs_readdata & i_host.notes_q[0].m);
      void'(i_host.notes_q.pop_front());
    end
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    finish_test();
  end
  // ==========================================================
  // Tests
  initial begin
    void'($urandom(60356));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    r(4'h6, 32'h40, 32'hff, "status");
    r(4'h5, 32'ha0, 32'hff, "drvhd");
    r(4'he, 32'h0, 32'hffffffff, "unmapped");
    w(4'ha, 32'h7);
    r(4'ha, 32'h7, 32'h7, "irq_en");
    $display("test reset done");
    for (int c = 0; c < 2; c++) begin
      lba = 28'($urandom_range(32'h0, 32'h0fff000));
      load(lba, 8'(2 - c));
      w(4'h0, 32'h20 + 32'(c));
      for (int s = 0; s < 2 - c; s++) begin
        while (!irq) @(posedge ref_clk);
        r(4'h9, 32'h1, 32'h1, "sector_irq");
        r(4'h6, 32'h08, 32'h88, "drq");
        w(4'hb, 32'h7);
        for (int k = 0; k < 256; k++)
          r(4'h8, {16'h0, lba[15:0] + 16'(s)} ^ 32'(k), 32'hffff, "word");
      end
      repeat (30) @(posedge ref_clk);
      chk("irq", 32'h0, {31'h0, irq});
      r(4'h6, 32'h0, 32'h88, "end_status");
    end
    $display("test read done");
    lba = 28'($urandom_range(32'h0, 32'h0fff000));
    w(4'hd, {4'h1, lba + 28'hc8});
    load(lba, 8'h0);
    w(4'h0, 32'h41);
    do r(4'h6, 32'h0, 32'h08, "no_drq"); while (q[7]);
    r(4'h9, 32'h4, 32'h4, "err_irq");
    r(4'h1, 32'h38, 32'hff, "left");
    lba = lba + 28'hc8;
    r(4'h2, {24'h0, lba[7:0]}, 32'hff, "fail_sec");
    r(4'h3, {24'h0, lba[15:8]}, 32'hff, "fail_cyl");
    w(4'h0, 32'h3);
    r(4'h7, 32'h11, 32'hff, "ext");
    w(4'hd, 32'h0);
    w(4'hb, 32'h7);
    load(lba, 8'h3);
    w(4'h0, 32'h40);
    do i_host.rd(4'h6, 32'h0, 32'h0, "", q); while (q[7]);
    r(4'h9, 32'h2, 32'h6, "verify_done");
    $display("test verify done");
    op = '{8'h70, 8'h10, 8'h5f};
    ext = '{8'h21, 8'h00, 8'h1f};
    w(4'hc, 32'h100);
    load(28'h200, 8'h1);
    for (int i = 0; i < 3; i++) begin
      w(4'h0, {24'h0, op[i] | {4'h0, 4'($urandom_range(0, 15))}});
      r(4'h6, {31'h0, ext[i] != 8'h0}, 32'h1, "err_bit");
      w(4'h0, 32'h3);
      r(4'h7, {24'h0, ext[i]}, 32'hff, "ext");
    end
    w(4'ha, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test commands done");
    finish_test();
  end
endmodule
